// ===== design/sudc_step.sv
// Next count for one counting step, wrapping per variant
`timescale 1ns/10ps

module sudc_step
#(
	parameter bit DECADE = 1'b1
)
(
	input  wire logic [3:0] count_i,
	input  wire logic       up_i,
	output logic      [3:0] step_o
);

	// ----------------------------------------------------------------
	// Step value
	// ----------------------------------------------------------------
	// Wrap at terminal count, otherwise plus or minus one
	always_comb
	begin
		if (sudc_pkg::sudc_terminal(count_i, up_i, DECADE))
		begin
			step_o = up_i ? sudc_pkg::CNT_ZERO : sudc_pkg::sudc_max(DECADE);
		end
		else if (up_i)
		begin
			step_o = 4'(count_i + sudc_pkg::CNT_ONE);
		end
		else
		begin
			step_o = 4'(count_i - sudc_pkg::CNT_ONE);
		end
	end

endmodule

// ===== design/sudc_top.sv
// Presettable 4-bit synchronous up/down counter with register bus access
//
// Contract
// - All state flip-flops change only on the rising edge of the single clock.
// - The four count outputs all change together on one edge.
// - A parameter selects a decade counter or a full-range 4-bit binary counter.
// - A low load input stops counting and copies the data inputs to the count at the next edge.
// - On a load each count bit is preset independently to the level of its data input.
// - The load input may be driven from a cascaded stage's carry so the stage reloads at terminal count.
// - Without load, the counter steps only when both count enables are low at the edge.
// - A high direction input counts up and a low one counts down.
// - The carry output goes low when trickle enable is low and the count is maximum going up or zero going down.
// - Count enables may change at any clock level and act on the count only at the next rising edge.
// - Enables, load and direction changes reach the count only at a clock edge; the carry follows trickle enable and direction at once.
// - The decade variant wraps nine to zero going up and zero to nine going down.
// - The binary variant wraps fifteen to zero going up and zero to fifteen going down.
`timescale 1ns/10ps

module sudc_top
#(
	parameter bit DECADE = 1'b1
)
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        load_n_i,
	input  wire logic        parallel_count_enable_n_i,
	input  wire logic        trickle_count_enable_n_i,
	input  wire logic        up_i,
	input  wire logic        load_data_bit0_i,
	input  wire logic        load_data_bit1_i,
	input  wire logic        load_data_bit2_i,
	input  wire logic        load_data_bit3_i,
	output logic             count_bit0_o,
	output logic             count_bit1_o,
	output logic             count_bit2_o,
	output logic             count_bit3_o,
	output logic             ripple_carry_n_o,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (sudc_pkg::CNT_W != 4)
	begin : g_bad_width
		$error("Counter width must be four bits");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [3:0]  count;
	logic [3:0]  next_count;
	logic [3:0]  step_value;
	logic [3:0]  load_data;
	logic        count_enabled;
	logic        terminal;
	logic [3:0]  preset;
	logic [3:0]  next_preset;
	logic        soft_load;
	logic        next_soft_load;
	logic        waiting;
	logic        next_waiting;
	logic [31:0] readdata;
	logic [31:0] next_readdata;
	logic        bus_take;

	// ----------------------------------------------------------------
	// Counter datapath
	// ----------------------------------------------------------------
	// Gather the four independent preset bits
	assign load_data     = {load_data_bit3_i, load_data_bit2_i, load_data_bit1_i, load_data_bit0_i};
	// Both enables low are needed to count
	assign count_enabled = ~parallel_count_enable_n_i & ~trickle_count_enable_n_i;
	assign terminal      = sudc_pkg::sudc_terminal(count, up_i, DECADE);

	// Plus or minus one step with wrap per variant
	sudc_step
	#(
		.DECADE (DECADE)
	)
	u_step
	(
		.count_i (count),
		.up_i    (up_i),
		.step_o  (step_value)
	);

	// Next count: pin load, then software preset, then counting, else hold
	always_comb
	begin
		if (!load_n_i)
		begin
			next_count = load_data;
		end
		else if (soft_load)
		begin
			next_count = preset;
		end
		else if (count_enabled)
		begin
			next_count = step_value;
		end
		else
		begin
			next_count = count;
		end
	end

	// All four bits register on the same rising edge
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			count <= sudc_pkg::CNT_RST;
		end
		else
		begin
			count <= next_count;
		end
	end

	// Count outputs straight from the count flip-flops
	assign count_bit0_o = count[0];
	assign count_bit1_o = count[1];
	assign count_bit2_o = count[2];
	assign count_bit3_o = count[3];

	// Carry follows direction and trickle enable without waiting for a clock
	assign ripple_carry_n_o = ~(~trickle_count_enable_n_i & terminal);

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	// A request is taken while waitrequest is high; it completes one cycle later
	assign bus_take = (avs_read_i | avs_write_i) & waiting;

	// Next values for waitrequest, read data, preset value and preset strobe
	always_comb
	begin
		next_waiting   = 1'b1;
		next_readdata  = readdata;
		next_preset    = preset;
		next_soft_load = 1'b0;
		if (bus_take)
		begin
			next_waiting = 1'b0;
		end
		if (avs_read_i && waiting)
		begin
			next_readdata = '0;
			if (avs_address_i == sudc_pkg::STATUS_OFS)
			begin
				next_readdata[sudc_pkg::ST_CNT_LSB +: 4] = count;
				next_readdata[sudc_pkg::ST_RC_BIT]       = ripple_carry_n_o;
				next_readdata[sudc_pkg::ST_UP_BIT]       = up_i;
				next_readdata[sudc_pkg::ST_SLD_BIT]      = soft_load;
			end
			else if (avs_address_i == sudc_pkg::PRESET_OFS)
			begin
				next_readdata[sudc_pkg::PRE_VAL_LSB +: 4] = preset;
			end
		end
		// Write takes effect at the edge where waitrequest is seen low
		if (avs_write_i && !waiting && avs_byteenable_i[0])
		begin
			if (avs_address_i == sudc_pkg::PRESET_OFS)
			begin
				next_preset    = avs_writedata_i[sudc_pkg::PRE_VAL_LSB +: 4];
				next_soft_load = 1'b1;
			end
		end
	end

	// Bus state registers
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			waiting   <= 1'b1;
			readdata  <= '0;
			preset    <= sudc_pkg::PRESET_RST;
			soft_load <= 1'b0;
		end
		else
		begin
			waiting   <= next_waiting;
			readdata  <= next_readdata;
			preset    <= next_preset;
			soft_load <= next_soft_load;
		end
	end

	assign avs_waitrequest_o = waiting;
	assign avs_readdata_o    = readdata;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	a_load_copies_data: assert property (
		!load_n_i |=> count == $past(load_data))
		else $error("Pin load did not copy the data inputs");

	a_hold_when_off: assert property (
		load_n_i && !soft_load && (parallel_count_enable_n_i || trickle_count_enable_n_i)
		|=> count == $past(count))
		else $error("Count moved while an enable was high");

	a_count_up_step: assert property (
		load_n_i && !soft_load && count_enabled && up_i && count < sudc_pkg::sudc_max(DECADE)
		|=> count == 4'($past(count) + 4'h1))
		else $error("Up count did not add one");

	a_count_down_step: assert property (
		load_n_i && !soft_load && count_enabled && !up_i && count != sudc_pkg::CNT_ZERO
		&& count <= sudc_pkg::sudc_max(DECADE)
		|=> count == 4'($past(count) - 4'h1))
		else $error("Down count did not subtract one");

	a_up_wrap_zero: assert property (
		load_n_i && !soft_load && count_enabled && up_i && count == sudc_pkg::sudc_max(DECADE)
		|=> count == sudc_pkg::CNT_ZERO)
		else $error("Up count did not wrap to zero");

	a_down_wrap_max: assert property (
		load_n_i && !soft_load && count_enabled && !up_i && count == sudc_pkg::CNT_ZERO
		|=> count == sudc_pkg::sudc_max(DECADE))
		else $error("Down count did not wrap to maximum");

	a_carry_low_term: assert property (
		!trickle_count_enable_n_i && up_i && count == sudc_pkg::sudc_max(DECADE) |-> !ripple_carry_n_o)
		else $error("Carry not low at maximum going up");

	a_carry_low_zero: assert property (
		!trickle_count_enable_n_i && !up_i && count == sudc_pkg::CNT_ZERO |-> !ripple_carry_n_o)
		else $error("Carry not low at zero going down");

	a_carry_high_off: assert property (
		trickle_count_enable_n_i || (count != sudc_pkg::CNT_ZERO && count != sudc_pkg::sudc_max(DECADE))
		|-> ripple_carry_n_o)
		else $error("Carry low without terminal count");

	a_bus_one_wait: assert property (
		bus_take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("Bus answer not exactly one cycle after the request");

	a_preset_loads: assert property (
		soft_load && load_n_i |=> count == $past(preset))
		else $error("Software preset not loaded");

	c_up_wrap: cover property (
		count_enabled && load_n_i && up_i && count == sudc_pkg::sudc_max(DECADE) ##1 count == sudc_pkg::CNT_ZERO);

	c_down_wrap: cover property (
		count_enabled && load_n_i && !up_i && count == sudc_pkg::CNT_ZERO ##1 count != sudc_pkg::CNT_ZERO);

	c_pin_load: cover property (!load_n_i ##1 load_n_i && count_enabled);

	c_bus_read: cover property (avs_read_i && !avs_waitrequest_o);

endmodule

// ===== shared/sudc_pkg.sv
// Shared constants and decode helpers for the synchronous up/down counter
package sudc_pkg;

	// ----------------------------------------------------------------
	// Counter geometry and values
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W       = 4;
	localparam logic [3:0]  CNT_RST     = 4'h0;
	localparam logic [3:0]  CNT_ZERO    = 4'h0;
	localparam logic [3:0]  CNT_ONE     = 4'h1;
	localparam logic [3:0]  DEC_MAX     = 4'h9;
	localparam logic [3:0]  BIN_MAX     = 4'hF;

	// ----------------------------------------------------------------
	// Register bus layout
	// ----------------------------------------------------------------
	localparam int unsigned BUS_AW      = 4;
	localparam int unsigned BUS_DW      = 32;
	localparam logic [3:0]  STATUS_OFS  = 4'h0;
	localparam logic [3:0]  PRESET_OFS  = 4'h4;
	localparam int unsigned ST_CNT_LSB  = 0;
	localparam int unsigned ST_RC_BIT   = 4;
	localparam int unsigned ST_UP_BIT   = 5;
	localparam int unsigned ST_SLD_BIT  = 6;
	localparam int unsigned PRE_VAL_LSB = 0;
	localparam logic [3:0]  PRESET_RST  = 4'h0;

	// Highest count of the chosen variant
	function automatic logic [3:0] sudc_max(input logic decade);
		sudc_max = decade ? DEC_MAX : BIN_MAX;
	endfunction

	// Terminal count: maximum going up, zero going down
	function automatic logic sudc_terminal(input logic [3:0] cnt, input logic up, input logic decade);
		sudc_terminal = up ? (cnt == sudc_max(decade)) : (cnt == CNT_ZERO);
	endfunction

endpackage

// ===== tb/sudc_stage_model.sv
// Behavioural next stage of a cascaded counter chain
`timescale 1ns/10ps

module sudc_stage_model
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       enable_n_i,
	input  wire logic       up_i,
	output logic      [3:0] count_o
);
	// ----------------------------------------------------------------
	// Binary stage stepping when the previous stage carries
	// ----------------------------------------------------------------
	logic [3:0] next_count;

	// Both enables of this stage hang on the previous carry
	always_comb
	begin
		next_count = count_o;
		if (!enable_n_i)
			next_count = up_i ? count_o + 4'h1 : count_o - 4'h1;
	end

	// Register on the rising edge only
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			count_o <= 4'h0;
		else
			count_o <= next_count;
	end
endmodule

// ===== tb/sync_updown_counter_tb_top.sv
// Self-checking bench for the synchronous up/down counter
`timescale 1ns/10ps

module sync_updown_counter_tb_top;
	// ----------------------------------------------------------------
	// Stimulus, results and bookkeeping
	// ----------------------------------------------------------------
	localparam int         LIMIT = 1000;
	localparam logic [3:0] MXD   = sudc_pkg::DEC_MAX;
	localparam logic [3:0] MXB   = sudc_pkg::BIN_MAX;
	// Pin steps: load_n, enable P, enable T, up, data[3:0]
	localparam logic [7:0] SEQ [28] = '{8'h17, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90, 8'hD0, 8'hB0, 8'h80, 8'h80,
		8'h80, 8'h80, 8'h80, 8'h60, 8'hC0, 8'hD0, 8'hC0, 8'h80, 8'h90, 8'h90, 8'h7A, 8'h75, 8'h7C, 8'h90, 8'h90,
		8'h90, 8'h90, 8'hE0};
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        load_n_i = 1'b1;
	logic        parallel_count_enable_n_i = 1'b1;
	logic        trickle_count_enable_n_i = 1'b1;
	logic        up_i = 1'b0;
	logic        load_data_bit0_i = 1'b0, load_data_bit1_i = 1'b0, load_data_bit2_i = 1'b0, load_data_bit3_i = 1'b0;
	logic        count_bit0_o, count_bit1_o, count_bit2_o, count_bit3_o, ripple_carry_n_o, avs_waitrequest_o;
	logic  [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
	logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
	wire   [3:0] cb, cnt_s;
	wire         rc_b;
	logic  [3:0] exp_d = 4'h0, exp_b = 4'h0, exp_s = 4'h0;
	int          n_errors = 0, total_checks = 0, cycles = 0;

	// Decade unit, binary unit and the cascaded next stage
	sudc_top i_dut
	(
		.sys_clk_i                 (sys_clk_i),
		.reset_i                   (reset_i),
		.load_n_i                  (load_n_i),
		.parallel_count_enable_n_i (parallel_count_enable_n_i),
		.trickle_count_enable_n_i  (trickle_count_enable_n_i),
		.up_i                      (up_i),
		.load_data_bit0_i          (load_data_bit0_i),
		.load_data_bit1_i          (load_data_bit1_i),
		.load_data_bit2_i          (load_data_bit2_i),
		.load_data_bit3_i          (load_data_bit3_i),
		.count_bit0_o              (count_bit0_o),
		.count_bit1_o              (count_bit1_o),
		.count_bit2_o              (count_bit2_o),
		.count_bit3_o              (count_bit3_o),
		.ripple_carry_n_o          (ripple_carry_n_o),
		.avs_address_i             (avs_address_i),
		.avs_read_i                (avs_read_i),
		.avs_write_i               (avs_write_i),
		.avs_writedata_i           (avs_writedata_i),
		.avs_byteenable_i          (avs_byteenable_i),
		.avs_readdata_o            (avs_readdata_o),
		.avs_waitrequest_o         (avs_waitrequest_o)
	);
	sudc_top
	#(
		.DECADE (1'b0)
	)
	i_bin
	(
		.sys_clk_i                 (sys_clk_i),
		.reset_i                   (reset_i),
		.load_n_i                  (load_n_i),
		.parallel_count_enable_n_i (parallel_count_enable_n_i),
		.trickle_count_enable_n_i  (trickle_count_enable_n_i),
		.up_i                      (up_i),
		.load_data_bit0_i          (load_data_bit0_i),
		.load_data_bit1_i          (load_data_bit1_i),
		.load_data_bit2_i          (load_data_bit2_i),
		.load_data_bit3_i          (load_data_bit3_i),
		.count_bit0_o              (cb[0]),
		.count_bit1_o              (cb[1]),
		.count_bit2_o              (cb[2]),
		.count_bit3_o              (cb[3]),
		.ripple_carry_n_o          (rc_b),
		.avs_address_i             (avs_address_i),
		.avs_read_i                (avs_read_i),
		.avs_write_i               (avs_write_i),
		.avs_writedata_i           (avs_writedata_i),
		.avs_byteenable_i          (avs_byteenable_i),
		.avs_readdata_o            (),
		.avs_waitrequest_o         ()
	);
	sudc_stage_model i_stage (.clk_i(sys_clk_i), .reset_i(reset_i), .enable_n_i(ripple_carry_n_o), .up_i(up_i),
		.count_o(cnt_s));

	// ----------------------------------------------------------------
	// Reference model and checking
	// ----------------------------------------------------------------
	function automatic logic [3:0] nxt(input logic [3:0] c, input logic [7:0] s, input logic [3:0] mx);
		nxt = c;
		if (!s[7])
			nxt = s[3:0];
		else if (!s[6] && !s[5])
			nxt = s[4] ? ((c == mx) ? 4'h0 : c + 4'h1) : ((c == 4'h0) ? mx : c - 4'h1);
	endfunction

	function automatic logic crn(input logic [3:0] c, input logic [7:0] s, input logic [3:0] mx);
		crn = !(!s[5] && (s[4] ? c == mx : c == 4'h0));
	endfunction

	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t pins got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t bus got %h expected %h", $time, got, exp);
		end
	endtask

	// Drive one pin step, then check the result of the previous one
	task automatic tick(input logic [7:0] s);
		@(posedge sys_clk_i);
		{load_n_i, parallel_count_enable_n_i, trickle_count_enable_n_i, up_i, load_data_bit3_i, load_data_bit2_i,
			load_data_bit1_i, load_data_bit0_i} <= s;
		@(negedge sys_clk_i);
		chk4({count_bit3_o, count_bit2_o, count_bit1_o, count_bit0_o}, exp_d);
		chk4(cb, exp_b);
		chk4(cnt_s, exp_s);
		chk4({3'h0, ripple_carry_n_o}, {3'h0, crn(exp_d, s, MXD)});
		chk4({3'h0, rc_b}, {3'h0, crn(exp_b, s, MXB)});
		if (!crn(exp_d, s, MXD))
			exp_s = s[4] ? exp_s + 4'h1 : exp_s - 4'h1;
		exp_d = nxt(exp_d, s, MXD);
		exp_b = nxt(exp_b, s, MXB);
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge sys_clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= b;
		do
			@(posedge sys_clk_i);
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic stop_test();
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout and test sequence
	// ----------------------------------------------------------------
	initial
	begin
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	// Cut a hang short
	always @(posedge sys_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			n_errors++;
			stop_test();
		end
	end

	// Pin sequences, then register access
	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		foreach (SEQ[i])
			tick(SEQ[i]);
		bus(1'b0, sudc_pkg::STATUS_OFS, 32'h0, 4'hF);
		chk32(q, {25'h0, 3'b001, exp_d});
		bus(1'b1, sudc_pkg::PRESET_OFS, 32'h3, 4'hF);
		exp_d = 4'h3;
		exp_b = 4'h3;
		tick(8'hE0);
		bus(1'b1, sudc_pkg::PRESET_OFS, 32'h6, 4'h0);
		bus(1'b1, 4'hC, 32'h9, 4'hF);
		tick(8'hE0);
		bus(1'b0, sudc_pkg::PRESET_OFS, 32'h0, 4'hF);
		chk32(q, 32'h3);
		bus(1'b0, 4'h8, 32'h0, 4'hF);
		chk32(q, 32'h0);
		stop_test();
	end
endmodule
